// ===== csx_consts.svh
/*
  Constants of the core register bank and external-data decoder.
  Assumes inclusion by csx_pkg and the design modules.
*/
// Overview of operation
// - Enabled xram serves moves 0000H-03FFH
// - Moves above 03FFH go to external bus
// - Disabled xram: all moves go external
// - Xram enable bit gates xram, reset clears
// - Registers 80-FFh, direct addressing only
// - Bit access only at addresses ending 0/8
// - Unimplemented locations and bits read one, except select bits 1-7
// - Separate 256-byte scratchpad, direct and indirect
// - Select bit 0 picks second pointer pair
// - Select bits 1-7 read zero
// - Baud double bit doubles serial rate
// - Framing enable turns bit 7 into flag
// - Two user flags without hardware effect
// - Power down stops every clock
// - Idle stops processor clock, peripherals run
// - Overflow flags: set, auto-clear, software writable
// - External requests: edge clears, level tracks
// - Type bits choose edge or level trigger
`ifndef CSX_CONSTS_SVH
`define CSX_CONSTS_SVH

`define CSX_ADDR_P0 8'h80
`define CSX_ADDR_SP 8'h81
`define CSX_ADDR_PAL 8'h82
`define CSX_ADDR_PAH 8'h83
`define CSX_ADDR_PBL 8'h84
`define CSX_ADDR_PBH 8'h85
`define CSX_ADDR_PSEL 8'h86
`define CSX_ADDR_POWER_CONTROL 8'h87
`define CSX_ADDR_TIMER_IRQ_CONTROL 8'h88
`define CSX_ADDR_PMR 8'hC4

`define CSX_RST_P0 8'hFF
`define CSX_RST_SP 8'h07
`define CSX_RST_ZERO 8'h00

`define CSX_POWER_CONTROL_BAUD 7
`define CSX_POWER_CONTROL_FERR 6
`define CSX_POWER_CONTROL_UF1 3
`define CSX_POWER_CONTROL_UF0 2
`define CSX_POWER_CONTROL_PD 1
`define CSX_POWER_CONTROL_IDL 0
`define CSX_POWER_CONTROL_UNUSED 8'h30

`define CSX_PMR_XEN 0
`define CSX_PMR_UNUSED 8'hFE

`define CSX_TIMER_IRQ_CONTROL_TF1 7
`define CSX_TIMER_IRQ_CONTROL_TR1 6
`define CSX_TIMER_IRQ_CONTROL_TF0 5
`define CSX_TIMER_IRQ_CONTROL_TR0 4
`define CSX_TIMER_IRQ_CONTROL_IE1 3
`define CSX_TIMER_IRQ_CONTROL_IT1 2
`define CSX_TIMER_IRQ_CONTROL_IE0 1
`define CSX_TIMER_IRQ_CONTROL_IT0 0

`define CSX_XRAM_TOP 16'h03FF
`define CSX_BITRAM_BASE 4'h2
`define CSX_READ_ONES 8'hFF

`endif

// ===== csx_pkg.sv
/*
  Types of the core register bank and external-data decoder.
  Assumes csx_consts.svh is on the include path.
*/
`include "csx_consts.svh"

package csx_pkg;
  typedef logic [7:0] csx_byte_t;
  typedef logic [15:0] csx_addr_t;
  typedef enum logic [1:0] {
    XM_IDLE,
    XM_INT,
    XM_EXT
  } csx_xstate_t;
endpackage

// ===== csx_xram.sv
/*
  1 KB on-chip external-data RAM held in flip-flops.
  Assumes one access per cycle; read data appears one cycle after re_i.
*/
`timescale 1ns/1ns
`default_nettype none
`include "csx_consts.svh"

module csx_xram (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Access
  input wire logic we_i,
  input wire logic re_i,
  input wire logic [9:0] addr_i,
  input wire csx_pkg::csx_byte_t wdata_i,
  output logic [7:0] rdata_o
);
  import csx_pkg::*;

  csx_byte_t mem_q [1024];
  csx_byte_t mem_d [1024];
  csx_byte_t rdata_q, rdata_d;

  always_comb begin
    mem_d = mem_q;
    rdata_d = rdata_q;
    if (we_i) begin
      mem_d[addr_i] = wdata_i;
    end
    if (re_i) begin
      rdata_d = mem_q[addr_i];
    end
  end

  always_ff @(posedge clk_i) begin
    mem_q <= mem_d;
    if (!rstn_i) begin
      rdata_q <= `CSX_RST_ZERO;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign rdata_o = rdata_q;
endmodule

`default_nettype wire

// ===== csx_sfr_xdata.sv
/*
  Core register bank, scratchpad and external-data move decoder.
  Assumes the core issues one register access and one data move at a time,
  all inputs synchronous to clk_i.
*/
`timescale 1ns/1ns
`default_nettype none
`include "csx_consts.svh"

module csx_sfr_xdata (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Register and scratchpad access
  input wire csx_pkg::csx_byte_t acc_addr_i,
  input wire logic acc_indirect_i,
  input wire logic acc_bit_i,
  input wire logic acc_wr_i,
  input wire logic acc_rd_i,
  input wire csx_pkg::csx_byte_t acc_wdata_i,
  output logic [7:0] acc_rdata_o,
  // External-data move from core
  input wire logic xmove_req_i,
  input wire logic xmove_wr_i,
  input wire csx_pkg::csx_addr_t xmove_addr_i,
  input wire csx_pkg::csx_byte_t xmove_wdata_i,
  output logic xmove_busy_o,
  output logic xmove_done_o,
  output logic [7:0] xmove_rdata_o,
  // External bus on ports 0 and 2
  output logic ext_req_o,
  output logic ext_wr_o,
  output logic [15:0] ext_addr_o,
  output logic [7:0] ext_wdata_o,
  input wire logic ext_ack_i,
  input wire csx_pkg::csx_byte_t ext_rdata_i,
  // Timer and interrupt events
  input wire logic t0_ovf_i,
  input wire logic t1_ovf_i,
  input wire logic t0_vec_i,
  input wire logic t1_vec_i,
  input wire logic ext0_vec_i,
  input wire logic ext1_vec_i,
  input wire logic ext_irq_pin_zero_i,
  input wire logic ext_irq_pin_one_i,
  input wire logic wake_i,
  // Control outputs
  output logic [15:0] active_data_pointer_o,
  output logic [7:0] port_zero_latch_o,
  output logic [7:0] stack_pointer_o,
  output logic t0_run_o,
  output logic t1_run_o,
  output logic t0_overflow_flag_o,
  output logic t1_overflow_flag_o,
  output logic ext0_request_o,
  output logic ext1_request_o,
  output logic baud_double_o,
  output logic framing_err_enable_o,
  output logic cpu_clk_en_o,
  output logic periph_clk_en_o
);
  import csx_pkg::*;

  function automatic logic sfr_known(input csx_byte_t a);
    sfr_known = (a >= `CSX_ADDR_P0 && a <= `CSX_ADDR_TIMER_IRQ_CONTROL) ||
                (a == `CSX_ADDR_PMR);
  endfunction

  // Register state
  csx_byte_t p0_q, p0_d, sp_q, sp_d, pal_q, pal_d, pah_q, pah_d;
  csx_byte_t pbl_q, pbl_d, pbh_q, pbh_d, power_control_q, power_control_d, timer_irq_control_q, timer_irq_control_d;
  logic psel_q, psel_d, xen_q, xen_d;
  logic pin0_q, pin1_q;
  csx_byte_t scratch_q [256];
  csx_byte_t scratch_d [256];
  csx_byte_t rdata_q, rdata_d;
  logic [15:0] active_data_pointer_q, active_data_pointer_d;
  logic cpu_en_q, cpu_en_d, per_en_q, per_en_d;

  // Access decode
  logic sfr_hit;
  csx_byte_t byte_addr, old_byte, new_byte, sfr_val;

  always_comb begin
    sfr_hit = acc_addr_i[7] && (acc_bit_i || !acc_indirect_i);
    if (acc_bit_i) begin
      byte_addr = acc_addr_i[7] ? {acc_addr_i[7:3], 3'h0}
                                : {`CSX_BITRAM_BASE, 1'b0, acc_addr_i[6:4]};
      if (!acc_addr_i[7]) begin
        byte_addr = {`CSX_BITRAM_BASE, acc_addr_i[6:3]};
      end
    end else begin
      byte_addr = acc_addr_i;
    end
    unique case (byte_addr)
      `CSX_ADDR_P0: sfr_val = p0_q;
      `CSX_ADDR_SP: sfr_val = sp_q;
      `CSX_ADDR_PAL: sfr_val = pal_q;
      `CSX_ADDR_PAH: sfr_val = pah_q;
      `CSX_ADDR_PBL: sfr_val = pbl_q;
      `CSX_ADDR_PBH: sfr_val = pbh_q;
      `CSX_ADDR_PSEL: sfr_val = {7'h00, psel_q};
      `CSX_ADDR_POWER_CONTROL: sfr_val = power_control_q | `CSX_POWER_CONTROL_UNUSED;
      `CSX_ADDR_TIMER_IRQ_CONTROL: sfr_val = timer_irq_control_q;
      `CSX_ADDR_PMR: sfr_val = `CSX_PMR_UNUSED | {7'h00, xen_q};
      default: sfr_val = `CSX_READ_ONES;
    endcase
    old_byte = sfr_hit ? sfr_val : scratch_q[byte_addr];
    new_byte = acc_wdata_i;
    if (acc_bit_i) begin
      new_byte = old_byte;
      new_byte[acc_addr_i[2:0]] = acc_wdata_i[0];
    end
    rdata_d = rdata_q;
    if (acc_rd_i) begin
      rdata_d = acc_bit_i ? {7'h00, old_byte[acc_addr_i[2:0]]} : old_byte;
    end
  end

  // Register writes and hardware events
  logic wr_sfr, fall0, fall1;

  always_comb begin
    wr_sfr = acc_wr_i && sfr_hit;
    scratch_d = scratch_q;
    if (acc_wr_i && !sfr_hit) begin
      scratch_d[byte_addr] = new_byte;
    end
    p0_d = p0_q;
    sp_d = sp_q;
    pal_d = pal_q;
    pah_d = pah_q;
    pbl_d = pbl_q;
    pbh_d = pbh_q;
    psel_d = psel_q;
    power_control_d = power_control_q;
    timer_irq_control_d = timer_irq_control_q;
    xen_d = xen_q;
    if (wr_sfr) begin
      unique case (byte_addr)
        `CSX_ADDR_P0: p0_d = new_byte;
        `CSX_ADDR_SP: sp_d = new_byte;
        `CSX_ADDR_PAL: pal_d = new_byte;
        `CSX_ADDR_PAH: pah_d = new_byte;
        `CSX_ADDR_PBL: pbl_d = new_byte;
        `CSX_ADDR_PBH: pbh_d = new_byte;
        `CSX_ADDR_PSEL: psel_d = new_byte[0];
        `CSX_ADDR_POWER_CONTROL: power_control_d = new_byte & ~`CSX_POWER_CONTROL_UNUSED;
        `CSX_ADDR_TIMER_IRQ_CONTROL: timer_irq_control_d = new_byte;
        `CSX_ADDR_PMR: xen_d = new_byte[`CSX_PMR_XEN];
        default: ;
      endcase
    end
    if (wake_i) begin
      power_control_d[`CSX_POWER_CONTROL_PD] = 1'b0;
      power_control_d[`CSX_POWER_CONTROL_IDL] = 1'b0;
    end
    if (t0_vec_i) begin
      timer_irq_control_d[`CSX_TIMER_IRQ_CONTROL_TF0] = 1'b0;
    end
    if (t1_vec_i) begin
      timer_irq_control_d[`CSX_TIMER_IRQ_CONTROL_TF1] = 1'b0;
    end
    if (t0_ovf_i) begin
      timer_irq_control_d[`CSX_TIMER_IRQ_CONTROL_TF0] = 1'b1;
    end
    if (t1_ovf_i) begin
      timer_irq_control_d[`CSX_TIMER_IRQ_CONTROL_TF1] = 1'b1;
    end
    fall0 = pin0_q && !ext_irq_pin_zero_i;
    fall1 = pin1_q && !ext_irq_pin_one_i;
    if (timer_irq_control_q[`CSX_TIMER_IRQ_CONTROL_IT0]) begin
      if (ext0_vec_i) begin
        timer_irq_control_d[`CSX_TIMER_IRQ_CONTROL_IE0] = 1'b0;
      end
      if (fall0) begin
        timer_irq_control_d[`CSX_TIMER_IRQ_CONTROL_IE0] = 1'b1;
      end
    end else begin
      timer_irq_control_d[`CSX_TIMER_IRQ_CONTROL_IE0] = !ext_irq_pin_zero_i;
    end
    if (timer_irq_control_q[`CSX_TIMER_IRQ_CONTROL_IT1]) begin
      if (ext1_vec_i) begin
        timer_irq_control_d[`CSX_TIMER_IRQ_CONTROL_IE1] = 1'b0;
      end
      if (fall1) begin
        timer_irq_control_d[`CSX_TIMER_IRQ_CONTROL_IE1] = 1'b1;
      end
    end else begin
      timer_irq_control_d[`CSX_TIMER_IRQ_CONTROL_IE1] = !ext_irq_pin_one_i;
    end
    active_data_pointer_d = psel_d ? {pbh_d, pbl_d} : {pah_d, pal_d};
    per_en_d = !power_control_d[`CSX_POWER_CONTROL_PD];
    cpu_en_d = !power_control_d[`CSX_POWER_CONTROL_PD] && !power_control_d[`CSX_POWER_CONTROL_IDL];
  end

  always_ff @(posedge clk_i) begin
    scratch_q <= scratch_d;
    if (!rstn_i) begin
      p0_q <= `CSX_RST_P0;
      sp_q <= `CSX_RST_SP;
      pal_q <= `CSX_RST_ZERO;
      pah_q <= `CSX_RST_ZERO;
      pbl_q <= `CSX_RST_ZERO;
      pbh_q <= `CSX_RST_ZERO;
      psel_q <= 1'b0;
      power_control_q <= `CSX_RST_ZERO;
      timer_irq_control_q <= `CSX_RST_ZERO;
      xen_q <= 1'b0;
      pin0_q <= 1'b1;
      pin1_q <= 1'b1;
      rdata_q <= `CSX_RST_ZERO;
      active_data_pointer_q <= 16'h0000;
      cpu_en_q <= 1'b1;
      per_en_q <= 1'b1;
    end else begin
      p0_q <= p0_d;
      sp_q <= sp_d;
      pal_q <= pal_d;
      pah_q <= pah_d;
      pbl_q <= pbl_d;
      pbh_q <= pbh_d;
      psel_q <= psel_d;
      power_control_q <= power_control_d;
      timer_irq_control_q <= timer_irq_control_d;
      xen_q <= xen_d;
      pin0_q <= ext_irq_pin_zero_i;
      pin1_q <= ext_irq_pin_one_i;
      rdata_q <= rdata_d;
      active_data_pointer_q <= active_data_pointer_d;
      cpu_en_q <= cpu_en_d;
      per_en_q <= per_en_d;
    end
  end

  // External-data move routing
  csx_xstate_t xs_q, xs_d;
  logic done_q, done_d, ereq_q, ereq_d, ewr_q, ewr_d;
  csx_addr_t eaddr_q, eaddr_d;
  csx_byte_t ewd_q, ewd_d, xrd_q, xrd_d, xram_rdata;
  logic go_int, go_ext, xram_we, xram_re;
  logic busy_q, busy_d;

  always_comb begin
    go_int = xmove_req_i && xs_q == XM_IDLE && xen_q &&
             xmove_addr_i <= `CSX_XRAM_TOP;
    go_ext = xmove_req_i && xs_q == XM_IDLE && !go_int;
    xram_we = go_int && xmove_wr_i;
    xram_re = go_int && !xmove_wr_i;
    xs_d = xs_q;
    done_d = 1'b0;
    ereq_d = 1'b0;
    ewr_d = ewr_q;
    eaddr_d = eaddr_q;
    ewd_d = ewd_q;
    xrd_d = xrd_q;
    unique case (xs_q)
      XM_IDLE: begin
        if (go_int) begin
          xs_d = XM_INT;
        end else if (go_ext) begin
          xs_d = XM_EXT;
          ereq_d = 1'b1;
          ewr_d = xmove_wr_i;
          eaddr_d = xmove_addr_i;
          ewd_d = xmove_wdata_i;
        end
      end
      XM_INT: begin
        xs_d = XM_IDLE;
        done_d = 1'b1;
        xrd_d = xram_rdata;
      end
      XM_EXT: begin
        if (ext_ack_i && !ereq_q) begin
          xs_d = XM_IDLE;
          done_d = 1'b1;
          xrd_d = ext_rdata_i;
        end
      end
      default: begin
        xs_d = XM_IDLE;
      end
    endcase
    busy_d = xs_d != XM_IDLE;
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      xs_q <= XM_IDLE;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      ereq_q <= 1'b0;
      ewr_q <= 1'b0;
      eaddr_q <= 16'h0000;
      ewd_q <= `CSX_RST_ZERO;
      xrd_q <= `CSX_RST_ZERO;
    end else begin
      xs_q <= xs_d;
      busy_q <= busy_d;
      done_q <= done_d;
      ereq_q <= ereq_d;
      ewr_q <= ewr_d;
      eaddr_q <= eaddr_d;
      ewd_q <= ewd_d;
      xrd_q <= xrd_d;
    end
  end

  csx_xram u_xram (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .we_i(xram_we),
    .re_i(xram_re),
    .addr_i(xmove_addr_i[9:0]),
    .wdata_i(xmove_wdata_i),
    .rdata_o(xram_rdata)
  );

  assign acc_rdata_o = rdata_q;
  assign xmove_busy_o = busy_q;
  assign xmove_done_o = done_q;
  assign xmove_rdata_o = xrd_q;
  assign ext_req_o = ereq_q;
  assign ext_wr_o = ewr_q;
  assign ext_addr_o = eaddr_q;
  assign ext_wdata_o = ewd_q;
  assign active_data_pointer_o = active_data_pointer_q;
  assign port_zero_latch_o = p0_q;
  assign stack_pointer_o = sp_q;
  assign t0_run_o = timer_irq_control_q[`CSX_TIMER_IRQ_CONTROL_TR0];
  assign t1_run_o = timer_irq_control_q[`CSX_TIMER_IRQ_CONTROL_TR1];
  assign t0_overflow_flag_o = timer_irq_control_q[`CSX_TIMER_IRQ_CONTROL_TF0];
  assign t1_overflow_flag_o = timer_irq_control_q[`CSX_TIMER_IRQ_CONTROL_TF1];
  assign ext0_request_o = timer_irq_control_q[`CSX_TIMER_IRQ_CONTROL_IE0];
  assign ext1_request_o = timer_irq_control_q[`CSX_TIMER_IRQ_CONTROL_IE1];
  assign baud_double_o = power_control_q[`CSX_POWER_CONTROL_BAUD];
  assign framing_err_enable_o = power_control_q[`CSX_POWER_CONTROL_FERR];
  assign cpu_clk_en_o = cpu_en_q;
  assign periph_clk_en_o = per_en_q;

  // Checks
  property p_int_route;
    @(posedge clk_i) disable iff (!rstn_i)
    go_int |=> xs_q == XM_INT ##1 (xmove_done_o && !ext_req_o);
  endproperty
  a_int_route: assert property (p_int_route)
    else $error("xram move not served internally");

  property p_high_ext;
    @(posedge clk_i) disable iff (!rstn_i)
    xmove_req_i && !xmove_busy_o && xmove_addr_i > `CSX_XRAM_TOP
      |=> ext_req_o && ext_addr_o == $past(xmove_addr_i);
  endproperty
  a_high_ext: assert property (p_high_ext)
    else $error("high move not sent to external bus");

  property p_dis_ext;
    @(posedge clk_i) disable iff (!rstn_i)
    xmove_req_i && !xmove_busy_o && !xen_q |=> ext_req_o;
  endproperty
  a_dis_ext: assert property (p_dis_ext)
    else $error("move not external while xram disabled");

  property p_pmr_read;
    @(posedge clk_i) disable iff (!rstn_i)
    acc_rd_i && !acc_bit_i && !acc_indirect_i && acc_addr_i == `CSX_ADDR_PMR
      |=> acc_rdata_o == (`CSX_PMR_UNUSED | {7'h00, $past(xen_q)});
  endproperty
  a_pmr_read: assert property (p_pmr_read)
    else $error("enable register read mismatch");

  property p_indirect;
    @(posedge clk_i) disable iff (!rstn_i)
    acc_wr_i && acc_indirect_i && !acc_bit_i && acc_addr_i == `CSX_ADDR_PSEL
      |=> $stable(psel_q);
  endproperty
  a_indirect: assert property (p_indirect)
    else $error("indirect write reached a register");

  property p_unimpl;
    @(posedge clk_i) disable iff (!rstn_i)
    acc_rd_i && !acc_bit_i && !acc_indirect_i && acc_addr_i[7] &&
      !sfr_known(acc_addr_i) |=> acc_rdata_o == `CSX_READ_ONES;
  endproperty
  a_unimpl: assert property (p_unimpl)
    else $error("unimplemented location read not all ones");

  property p_active_data_pointer;
    @(posedge clk_i) disable iff (!rstn_i)
    active_data_pointer_o == (psel_q ? {pbh_q, pbl_q} : {pah_q, pal_q});
  endproperty
  a_active_data_pointer: assert property (p_active_data_pointer)
    else $error("active pointer pair wrong");

  property p_psel_zero;
    @(posedge clk_i) disable iff (!rstn_i)
    acc_rd_i && !acc_bit_i && !acc_indirect_i && acc_addr_i == `CSX_ADDR_PSEL
      |=> acc_rdata_o[7:1] == 7'h00;
  endproperty
  a_psel_zero: assert property (p_psel_zero)
    else $error("reserved select bits not zero");

  property p_ovf_set;
    @(posedge clk_i) disable iff (!rstn_i)
    t0_ovf_i |=> t0_overflow_flag_o;
  endproperty
  a_ovf_set: assert property (p_ovf_set)
    else $error("overflow flag not set");

  property p_level;
    @(posedge clk_i) disable iff (!rstn_i)
    !timer_irq_control_q[`CSX_TIMER_IRQ_CONTROL_IT0] |=> ext0_request_o == !$past(ext_irq_pin_zero_i);
  endproperty
  a_level: assert property (p_level)
    else $error("level request does not track pin");

  property p_edge;
    @(posedge clk_i) disable iff (!rstn_i)
    timer_irq_control_q[`CSX_TIMER_IRQ_CONTROL_IT1] && fall1 |=> ext1_request_o;
  endproperty
  a_edge: assert property (p_edge)
    else $error("falling edge not captured");

  property p_pd;
    @(posedge clk_i) disable iff (!rstn_i)
    power_control_q[`CSX_POWER_CONTROL_PD] |-> !periph_clk_en_o && !cpu_clk_en_o;
  endproperty
  a_pd: assert property (p_pd)
    else $error("clocks run in power down");

  property p_idle;
    @(posedge clk_i) disable iff (!rstn_i)
    power_control_q[`CSX_POWER_CONTROL_IDL] && !power_control_q[`CSX_POWER_CONTROL_PD]
      |-> !cpu_clk_en_o && periph_clk_en_o;
  endproperty
  a_idle: assert property (p_idle)
    else $error("idle clock gating wrong");

  c_int_move: cover property (@(posedge clk_i) go_int ##2 xmove_done_o);
  c_ext_move: cover property (@(posedge clk_i) ext_req_o ##[1:20] xmove_done_o);
  c_t0_vec: cover property (@(posedge clk_i) t0_overflow_flag_o ##1 t0_vec_i);
endmodule

`default_nettype wire

// ===== csx_bus_model.sv
/*
  Behavioural external data bus on ports 0 and 2: stores writes, answers
  reads, acknowledges after a short or long wait.
  Assumes requests come one at a time from the decoder, synchronous to clk_i.
*/
`timescale 1ns/1ns
`default_nettype none

module csx_bus_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Request from decoder
  input wire logic ext_req_i,
  input wire logic ext_wr_i,
  input wire logic [15:0] ext_addr_i,
  input wire logic [7:0] ext_wdata_i,
  // Wait selection
  input wire logic slow_i,
  // Answer
  output logic ext_ack_o,
  output logic [7:0] ext_rdata_o
);
  logic [7:0] mem [logic [15:0]];

  initial begin
    ext_ack_o = 1'b0;
    ext_rdata_o = 8'h00;
  end

  // Unwritten locations answer with a pattern derived from the address
  always @(posedge clk_i) begin
    if (rstn_i && ext_req_i) begin
      if (ext_wr_i)
        mem[ext_addr_i] = ext_wdata_i;
      repeat (slow_i ? 5 : 1) @(posedge clk_i);
      ext_ack_o <= 1'b1;
      ext_rdata_o <= mem.exists(ext_addr_i) ? mem[ext_addr_i] :
                     (ext_addr_i[7:0] ^ 8'hA5);
      @(posedge clk_i);
      ext_ack_o <= 1'b0;
      // Data no longer valid once the acknowledge has gone
      ext_rdata_o <= ~ext_rdata_o;
    end
  end
endmodule

`default_nettype wire

// ===== tb_csx_sfr_xdata.sv
/*
  Self-checking bench for the register bank and data-move decoder.
  Assumes csx_pkg, csx_xram, csx_sfr_xdata and csx_bus_model compiled first.
*/
`timescale 1ns/1ns
`default_nettype none

module tb_csx_sfr_xdata;
  import csx_pkg::*;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  csx_byte_t acc_addr_i = 8'h00, acc_wdata_i = 8'h00;
  logic acc_indirect_i = 1'b0, acc_bit_i = 1'b0;
  logic acc_wr_i = 1'b0, acc_rd_i = 1'b0;
  logic xmove_req_i = 1'b0, xmove_wr_i = 1'b0;
  csx_addr_t xmove_addr_i = 16'h0000;
  csx_byte_t xmove_wdata_i = 8'h00;
  logic [6:0] evp = 7'h00;
  logic [1:0] pin_n = 2'b11;
  logic slow = 1'b0;
  logic [7:0] acc_rdata_o, xmove_rdata_o, ext_wdata_o;
  logic [7:0] port_zero_latch_o, stack_pointer_o;
  logic [15:0] ext_addr_o, active_data_pointer_o;
  logic xmove_busy_o, xmove_done_o, ext_req_o, ext_wr_o, ext_ack_i;
  csx_byte_t ext_rdata_i;
  logic [1:0] run, ovf, ereq;
  logic baud_double_o, framing_err_enable_o, cpu_clk_en_o, periph_clk_en_o;
  int miscompares = 0;
  int compares = 0;
  int ext_cnt = 0;
  logic [7:0] rst_a [11] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'h84, 8'h85,
                             8'h86, 8'h87, 8'h88, 8'hC4, 8'h8F};
  logic [7:0] rst_e [11] = '{8'hFF, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00,
                             8'h00, 8'h30, 8'h00, 8'hFE, 8'hFF};

  always #4 clk_i = ~clk_i;

  csx_sfr_xdata dut (
    .clk_i, .rstn_i, .acc_addr_i, .acc_indirect_i, .acc_bit_i, .acc_wr_i,
    .acc_rd_i, .acc_wdata_i, .acc_rdata_o, .xmove_req_i, .xmove_wr_i,
    .xmove_addr_i, .xmove_wdata_i, .xmove_busy_o, .xmove_done_o,
    .xmove_rdata_o, .ext_req_o, .ext_wr_o, .ext_addr_o, .ext_wdata_o,
    .ext_ack_i, .ext_rdata_i, .t0_ovf_i(evp[0]), .t1_ovf_i(evp[1]),
    .t0_vec_i(evp[2]), .t1_vec_i(evp[3]), .ext0_vec_i(evp[4]),
    .ext1_vec_i(evp[5]), .ext_irq_pin_zero_i(pin_n[0]),
    .ext_irq_pin_one_i(pin_n[1]), .wake_i(evp[6]), .active_data_pointer_o,
    .port_zero_latch_o, .stack_pointer_o, .t0_run_o(run[0]),
    .t1_run_o(run[1]), .t0_overflow_flag_o(ovf[0]),
    .t1_overflow_flag_o(ovf[1]), .ext0_request_o(ereq[0]),
    .ext1_request_o(ereq[1]), .baud_double_o, .framing_err_enable_o,
    .cpu_clk_en_o, .periph_clk_en_o
  );

  csx_bus_model bus (
    .clk_i, .rstn_i, .ext_req_i(ext_req_o), .ext_wr_i(ext_wr_o),
    .ext_addr_i(ext_addr_o), .ext_wdata_i(ext_wdata_o), .slow_i(slow),
    .ext_ack_o(ext_ack_i), .ext_rdata_o(ext_rdata_i)
  );

  always @(posedge clk_i) begin
    if (ext_req_o === 1'b1)
      ext_cnt <= ext_cnt + 1;
  end

  task chk(input logic [15:0] got, exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task end_of_test;
    if (miscompares == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task acc(input logic w, ind, bt, input logic [7:0] a, d);
    @(posedge clk_i);
    acc_addr_i <= a;
    acc_indirect_i <= ind;
    acc_bit_i <= bt;
    acc_wr_i <= w;
    acc_rd_i <= !w;
    acc_wdata_i <= d;
    @(posedge clk_i);
    acc_wr_i <= 1'b0;
    acc_rd_i <= 1'b0;
    #1;
  endtask

  task wr(input logic [7:0] a, d, input logic ind = 1'b0, bt = 1'b0);
    acc(1'b1, ind, bt, a, d);
  endtask

  task rd(input logic [7:0] a, e, input logic ind = 1'b0, bt = 1'b0);
    acc(1'b0, ind, bt, a, 8'h00);
    chk(acc_rdata_o, e);
  endtask

  task pulse(input int i);
    @(posedge clk_i);
    evp[i] <= 1'b1;
    @(posedge clk_i);
    evp[i] <= 1'b0;
    @(posedge clk_i);
    #1;
  endtask

  task setpin(input int k, input logic v);
    @(posedge clk_i);
    pin_n[k] <= v;
    repeat (2) @(posedge clk_i);
    #1;
  endtask

  task xm(input logic w, input logic [15:0] a, input logic [7:0] d, e,
          input int ext);
    int n;
    int c0;
    c0 = ext_cnt;
    @(posedge clk_i);
    xmove_req_i <= 1'b1;
    xmove_wr_i <= w;
    xmove_addr_i <= a;
    xmove_wdata_i <= d;
    @(posedge clk_i);
    xmove_req_i <= 1'b0;
    #1;
    chk(xmove_busy_o, 1'b1);
    n = 0;
    while (xmove_done_o !== 1'b1 && n < 40) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    chk(xmove_done_o, 1'b1);
    chk(xmove_busy_o, 1'b0);
    if (!w)
      chk(xmove_rdata_o, e);
    chk(ext_cnt - c0, ext);
    if (ext != 0)
      chk(ext_addr_o, a);
    else
      chk(n, 1);
  endtask

  initial begin
    repeat (5000) @(posedge clk_i);
    miscompares++;
    end_of_test();
  end

  initial begin
    repeat (4) @(posedge clk_i);
    rstn_i <= 1'b1;
    #1;
    chk({port_zero_latch_o, stack_pointer_o}, 16'hFF07);
    chk({cpu_clk_en_o, periph_clk_en_o, xmove_busy_o, ext_req_o}, 4'hC);
    for (int i = 0; i < 11; i++)
      rd(rst_a[i], rst_e[i]);
    wr(8'h82, 8'h34);
    wr(8'h83, 8'h12);
    wr(8'h84, 8'h78);
    wr(8'h85, 8'h56);
    chk(active_data_pointer_o, 16'h1234);
    wr(8'h86, 8'hFF);
    rd(8'h86, 8'h01);
    chk(active_data_pointer_o, 16'h5678);
    wr(8'h86, 8'h00);
    chk(active_data_pointer_o, 16'h1234);
    wr(8'h80, 8'h3C);
    wr(8'h81, 8'h5B);
    chk({port_zero_latch_o, stack_pointer_o}, 16'h3C5B);
    wr(8'h30, 8'h11);
    rd(8'h30, 8'h11, 1'b1);
    wr(8'h90, 8'hA5, 1'b1);
    rd(8'h90, 8'hA5, 1'b1);
    rd(8'h90, 8'hFF);
    wr(8'h82, 8'h5A, 1'b1);
    wr(8'h86, 8'h01, 1'b1);
    rd(8'h86, 8'h01, 1'b1);
    rd(8'h86, 8'h00);
    chk(active_data_pointer_o, 16'h1234);
    wr(8'h20, 8'h00);
    wr(8'h05, 8'h01, 1'b0, 1'b1);
    rd(8'h20, 8'h20);
    rd(8'h05, 8'h01, 1'b0, 1'b1);
    wr(8'h8C, 8'h01, 1'b0, 1'b1);
    wr(8'h8E, 8'h01, 1'b0, 1'b1);
    chk(run, 2'b11);
    rd(8'h88, 8'h50);
    wr(8'h8C, 8'h00, 1'b0, 1'b1);
    chk(run, 2'b10);
    wr(8'h87, 8'hCC);
    rd(8'h87, 8'hFC);
    chk({baud_double_o, framing_err_enable_o, cpu_clk_en_o,
         periph_clk_en_o}, 4'hF);
    wr(8'h87, 8'h01);
    @(posedge clk_i);
    #1;
    chk({cpu_clk_en_o, periph_clk_en_o}, 2'b01);
    pulse(6);
    chk({cpu_clk_en_o, periph_clk_en_o}, 2'b11);
    wr(8'h87, 8'h02);
    @(posedge clk_i);
    #1;
    chk({cpu_clk_en_o, periph_clk_en_o}, 2'b00);
    pulse(6);
    chk({cpu_clk_en_o, periph_clk_en_o}, 2'b11);
    rd(8'h87, 8'h30);
    wr(8'h88, 8'h00);
    pulse(0);
    rd(8'h88, 8'h20);
    pulse(1);
    rd(8'h88, 8'hA0);
    pulse(2);
    rd(8'h88, 8'h80);
    pulse(3);
    rd(8'h88, 8'h00);
    wr(8'h88, 8'hA0);
    chk(ovf, 2'b11);
    wr(8'h88, 8'h00);
    chk(ovf, 2'b00);
    for (int k = 0; k < 2; k++) begin
      wr(8'h88, 8'h05);
      setpin(k, 1'b0);
      chk(ereq[k], 1'b1);
      rd(8'h88, 8'h05 | (8'h02 << (2 * k)));
      pulse(4 + k);
      chk(ereq[k], 1'b0);
      setpin(k, 1'b1);
      wr(8'h88, 8'h00);
      setpin(k, 1'b0);
      chk(ereq[k], 1'b1);
      pulse(4 + k);
      chk(ereq[k], 1'b1);
      setpin(k, 1'b1);
      chk(ereq[k], 1'b0);
    end
    xm(1'b0, 16'h0010, 8'h00, 8'hB5, 1);
    wr(8'hC4, 8'h01);
    rd(8'hC4, 8'hFF);
    xm(1'b1, 16'h03FF, 8'h5A, 8'h00, 0);
    xm(1'b0, 16'h03FF, 8'h00, 8'h5A, 0);
    xm(1'b1, 16'h0000, 8'h3C, 8'h00, 0);
    xm(1'b0, 16'h0000, 8'h00, 8'h3C, 0);
    slow = 1'b1;
    xm(1'b1, 16'h0400, 8'hC3, 8'h00, 1);
    xm(1'b0, 16'h0400, 8'h00, 8'hC3, 1);
    slow = 1'b0;
    xm(1'b0, 16'hFFFF, 8'h00, 8'h5A, 1);
    wr(8'hC4, 8'h00);
    xm(1'b0, 16'h03FF, 8'h00, 8'h5A, 1);
    xm(1'b0, 16'h0000, 8'h00, 8'hA5, 1);
    end_of_test();
  end
endmodule

`default_nettype wire
